// file: verification/qrr_link_sva.sv
// checker for the byte link between host end and device end
`timescale 1ns/1ps
module qrr_link_sva (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_last,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   logic [7:0] cmd_q;
   logic first_q;
   logic [2:0] cnt_q;
   logic h_take;
   logic d_take;
   logic rd;
   assign h_take = h2d_valid && h2d_ready;
   assign d_take = d2h_valid && d2h_ready;
   assign rd = (cmd_q >= 8'h20) && (cmd_q <= 8'h26); // commands answered with five bytes
   // remember the command byte that opens each frame
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_q <= 8'h00;
         first_q <= 1'b1;
      end else if (h_take) begin
         cmd_q <= first_q ? h2d_data : cmd_q;
         first_q <= h2d_last;
      end
   end
   // count answer bytes taken since the last frame byte
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= h_take ? 3'h0 : (d_take ? cnt_q + 3'h1 : cnt_q);
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   a_answer_after_exec: assert property (h_take && h2d_last |=> !d2h_valid ##1 d2h_valid)
      else $error("answer not two edges after last frame byte");
   a_refuse_while_answer: assert property (d2h_valid |-> !h2d_ready)
      else $error("frame byte accepted while answering");
   a_ack_is_one: assert property (d2h_valid && !rd && cnt_q == 3'h0 |-> d2h_data == 8'h01)
      else $error("acknowledge byte not one");
   a_ack_single_byte: assert property (d_take && !rd |=> !d2h_valid)
      else $error("more than one acknowledge byte");
   a_reply_keeps_going: assert property (d_take && rd && cnt_q < 3'h4 |=> d2h_valid)
      else $error("reply shorter than five bytes");
   a_reply_stops_five: assert property (d_take && rd && cnt_q == 3'h4 |=> !d2h_valid)
      else $error("reply longer than five bytes");
   a_dac_tail_zero: assert property (d2h_valid && cmd_q == 8'h25 && cnt_q >= 3'h2 |-> d2h_data == 8'h00)
      else $error("level reply tail not zero");
   a_ident_tail_zero: assert property (d2h_valid && cmd_q == 8'h23 && cnt_q == 3'h4 |-> d2h_data == 8'h00)
      else $error("identity reply last byte not zero");
   c_ident_reply: cover property (d_take && cmd_q == 8'h23 && cnt_q == 3'h4);
   c_drain_reply: cover property (d_take && cmd_q == 8'h26 && cnt_q == 3'h4);
   c_ack_reply: cover property (d_take && !rd);
endmodule : qrr_link_sva

// file: verification/query_register_responder_bench.sv
// self-checking bench joining host end and device end
`timescale 1ns/1ps
module query_register_responder_bench;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic bridge_ready = 1'b0;
   logic serial_mode = 1'b0;
   logic list_wr_en = 1'b0;
   logic [10:0] list_wr_index = 11'h000;
   logic [39:0] list_wr_freq = 40'h0;
   logic req_valid = 1'b0;
   logic [7:0] req_cmd = 8'h00;
   logic [39:0] req_param = 40'h0;
   logic [2:0] req_param_bytes = 3'h0;
   logic req_expect_reply = 1'b0;
   logic [31:0] serial_number = 32'h0a1b2c3d;
   logic [31:0] hw_revision = 32'h3fc00000;
   logic [31:0] fw_revision = 32'h40200000;
   logic [7:0] date_year = 8'h19;
   logic [7:0] date_month = 8'h0b;
   logic [7:0] date_day = 8'h1c;
   logic [7:0] date_hour = 8'h0e;
   logic [15:0] level_dac_code = 16'ha55a;
   logic req_ready, resp_valid, frame_error;
   logic [39:0] resp_data;
   logic [7:0] last_cmd;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // ----------------------------------------
   // both ends and the checker
   // ----------------------------------------
   qrr_link_if qrr_link_if_inst();
   qrr_host qrr_host_inst(.clk_sys, .nrst, .link(qrr_link_if_inst), .bridge_ready, .req_valid, .req_cmd,
      .req_param, .req_param_bytes, .req_expect_reply, .req_ready, .resp_valid, .resp_data);
   qrr_device qrr_device_inst(.clk_sys, .nrst, .link(qrr_link_if_inst), .serial_mode, .serial_number,
      .hw_revision, .fw_revision, .date_year, .date_month, .date_day, .date_hour, .level_dac_code,
      .list_wr_en, .list_wr_index, .list_wr_freq, .last_cmd, .frame_error);
   qrr_link_sva qrr_link_sva_inst(.clk_sys, .nrst, .h2d_data(qrr_link_if_inst.h2d_data),
      .h2d_valid(qrr_link_if_inst.h2d_valid), .h2d_last(qrr_link_if_inst.h2d_last),
      .h2d_ready(qrr_link_if_inst.h2d_ready), .d2h_data(qrr_link_if_inst.d2h_data),
      .d2h_valid(qrr_link_if_inst.d2h_valid), .d2h_ready(qrr_link_if_inst.d2h_ready));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one frame through the host end, waiting for its answer
   task automatic do_cmd(input logic [7:0] cmd, input logic [39:0] prm, input logic [2:0] nb, input logic rep);
      int i;
      i = 0;
      @(negedge clk_sys);
      while (req_ready !== 1'b1 && i < 300) begin
         @(negedge clk_sys);
         i++;
      end
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_param <= prm;
      req_param_bytes <= nb;
      req_expect_reply <= rep;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      i = 0;
      while (resp_valid !== 1'b1 && i < 300) begin
         @(negedge clk_sys);
         i++;
      end
      check("resp_valid", {39'h0, resp_valid}, 40'h1);
   endtask : do_cmd
   function automatic logic [31:0] ident(input int s);
      case (s)
         0: return serial_number;
         1: return hw_revision;
         2: return fw_revision;
         3: return {date_year, date_month, date_day, date_hour};
         default: return 32'h0;
      endcase
   endfunction : ident
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_ident();
      for (int s = 0; s < 8; s++) begin
         do_cmd(8'h23, {37'h0, s[2:0]}, 3'h1, 1'b1);
         check("identity", resp_data, {ident(s), 8'h00});
      end
      check("last_cmd", {32'h0, last_cmd}, 40'h23);
   endtask : t_ident
   task automatic t_list();
      @(posedge clk_sys);
      list_wr_en <= 1'b1;
      list_wr_index <= 11'h7ff;
      list_wr_freq <= 40'h04_a817_c800;
      @(posedge clk_sys);
      list_wr_index <= 11'h000;
      list_wr_freq <= 40'hf1_0203_0405;
      @(posedge clk_sys);
      list_wr_en <= 1'b0;
      do_cmd(8'h24, 40'h7ff, 3'h2, 1'b1);
      check("list top", resp_data, 40'h04_a817_c800);
      do_cmd(8'h24, 40'h000, 3'h2, 1'b1);
      check("list zero", resp_data, 40'hf1_0203_0405);
   endtask : t_list
   task automatic t_ack();
      do_cmd(8'h10, 40'h00_0000_abcd, 3'h2, 1'b0);
      check("ack", {32'h0, resp_data[7:0]}, 40'h01);
      check("last_cmd", {32'h0, last_cmd}, 40'h10);
   endtask : t_ack
   task automatic t_drain();
      @(posedge clk_sys);
      serial_mode <= 1'b1;
      level_dac_code <= 16'h0f3c;
      repeat (4) @(posedge clk_sys);
      do_cmd(8'h25, 40'h0, 3'h1, 1'b1);
      check("level", resp_data, 40'h0f3c_000000);
      do_cmd(8'h23, 40'h3, 3'h1, 1'b1);
      do_cmd(8'h26, 40'h0, 3'h5, 1'b1);
      check("drain", resp_data, {ident(3), 8'h00});
      check("good drain flag", {39'h0, frame_error}, 40'h0);
      do_cmd(8'h26, 40'h0, 3'h5, 1'b1);
      check("drain cleared", resp_data, 40'h0);
      @(posedge clk_sys);
      serial_mode <= 1'b0;
      repeat (4) @(posedge clk_sys);
      do_cmd(8'h26, 40'h0, 3'h5, 1'b1);
      check("bad drain flag", {39'h0, frame_error}, 40'h1);
   endtask : t_drain
   // ----------------------------------------
   // clock, run limit and main sequence
   // ----------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // cut a hang short well above the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      bridge_ready <= 1'b1;
      t_ident();
      t_list();
      t_ack();
      do_cmd(8'h25, 40'h0, 3'h1, 1'b1);
      check("level", resp_data, 40'ha55a_000000);
      t_drain();
      end_of_test();
   end
endmodule : query_register_responder_bench

// file: verilog/qrr_defs.svh
// constants for the query register responder
`ifndef QRR_DEFS_SVH
`define QRR_DEFS_SVH
`define QRR_CMD_QUERY_BASE 8'h20
`define QRR_CMD_QUERY_LAST 8'h25
`define QRR_CMD_IDENTITY 8'h23
`define QRR_CMD_LIST_POINT 8'h24
`define QRR_CMD_LEVEL_DAC 8'h25
`define QRR_CMD_DRAIN 8'h26
`define QRR_ACK_BYTE 8'h01
`define QRR_REPLY_BYTES 3'h5
`define QRR_DRAIN_PARAM_BYTES 3'h5
`define QRR_LIST_POINTS 12'h800
`define QRR_SEL_SERIAL 3'h0
`define QRR_SEL_HW_REV 3'h1
`define QRR_SEL_FW_REV 3'h2
`define QRR_SEL_DATE 3'h3
`endif

// file: verilog/qrr_device.sv
// device end: command interpreter that stages and returns replies
// Function
// - identity selector 0-3 picks serial, revisions, date
// - identity reply word sits in bits 39:8
// - date word packs year, month, day, hour
// - identity query stages reply immediately
// - serial results wait for drain command; the code also sends each query reply at once, in either mode
// - list index returns 40-bit frequency
// - dac code in bits 39:24, rest zero
// - drain only on serial, zero parameters
// - drain returns reply of last query
// - frame is command byte plus parameters
// - parameters assembled most significant first
// - ack byte one only after execution
// - host reads ack before next command
// - reply readable once query written
// - read returns five bytes, zero padded
// - host initialises bridge before commands
`timescale 1ns/1ps
`include "qrr_defs.svh"
module qrr_device (
   input wire logic clk_sys,
   input wire logic nrst,
   qrr_link_if.device link,
   input wire logic serial_mode,
   input wire logic [31:0] serial_number,
   input wire logic [31:0] hw_revision,
   input wire logic [31:0] fw_revision,
   input wire logic [7:0] date_year,
   input wire logic [7:0] date_month,
   input wire logic [7:0] date_day,
   input wire logic [7:0] date_hour,
   input wire logic [15:0] level_dac_code,
   input wire logic list_wr_en,
   input wire logic [10:0] list_wr_index,
   input wire logic [39:0] list_wr_freq,
   output logic [7:0] last_cmd,
   output logic frame_error
);
   typedef enum {QRR_D_CMD, QRR_D_PARAM, QRR_D_EXEC, QRR_D_SEND} qrr_dev_state_t;
   qrr_dev_state_t state_q;
   logic [7:0] cmd_q;
   logic [39:0] param_q;
   qrr_pkg::qrr_reply_t staged_q;
   qrr_pkg::qrr_reply_t send_q;
   logic [2:0] send_left_q;
   logic [2:0] param_cnt_q;
   logic serial_m1_q;
   logic serial_q;
   logic [7:0] last_cmd_q;
   logic frame_error_q;
   logic [39:0] list_mem [0:`QRR_LIST_POINTS-1];

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic is_query(input logic [7:0] c);
      is_query = (c >= `QRR_CMD_QUERY_BASE) && (c <= `QRR_CMD_QUERY_LAST);
   endfunction : is_query

   // identity word by selector, zero for undefined codes
   function automatic logic [31:0] identity_word(input logic [2:0] sel, input logic [31:0] sn,
      input logic [31:0] hw, input logic [31:0] fw, input logic [31:0] dt);
      case (sel)
         `QRR_SEL_SERIAL: identity_word = sn;
         `QRR_SEL_HW_REV: identity_word = hw;
         `QRR_SEL_FW_REV: identity_word = fw;
         `QRR_SEL_DATE: identity_word = dt;
         default: identity_word = 32'h0000_0000;
      endcase
   endfunction : identity_word

   // -----------------------------------------------------------
   // interface mode pin synchroniser
   // -----------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_m1_q <= 1'b0;
         serial_q <= 1'b0;
      end else begin
         serial_m1_q <= serial_mode;
         serial_q <= serial_m1_q;
      end
   end

   // list point memory, written from the sweep side
   // read only in the exec cycle, once the whole index has been assembled
   always_ff @(posedge clk_sys) begin
      if (list_wr_en) begin
         list_mem[list_wr_index] <= list_wr_freq;
      end
   end

   // -----------------------------------------------------------
   // frame reception and execution
   // -----------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= QRR_D_CMD;
         cmd_q <= 8'h00;
         param_q <= 40'h00_0000_0000;
         param_cnt_q <= 3'h0;
         staged_q <= 40'h00_0000_0000;
         send_q <= 40'h00_0000_0000;
         send_left_q <= 3'h0;
         last_cmd_q <= 8'h00;
         frame_error_q <= 1'b0;
      end else begin
         case (state_q)
            QRR_D_CMD: begin
               if (link.h2d_valid) begin
                  cmd_q <= link.h2d_data;
                  param_q <= 40'h00_0000_0000;
                  param_cnt_q <= 3'h0;
                  frame_error_q <= 1'b0;
                  state_q <= link.h2d_last ? QRR_D_EXEC : QRR_D_PARAM;
               end
            end
            QRR_D_PARAM: begin
               if (link.h2d_valid) begin
                  param_q <= {param_q[31:0], link.h2d_data};
                  param_cnt_q <= param_cnt_q + 3'h1;
                  if (link.h2d_last) begin
                     state_q <= QRR_D_EXEC;
                  end
               end
            end
            QRR_D_EXEC: begin
               // one cycle: index and identity word are complete here
               last_cmd_q <= cmd_q;
               send_left_q <= `QRR_REPLY_BYTES;
               state_q <= QRR_D_SEND;
               if (cmd_q == `QRR_CMD_IDENTITY) begin
                  staged_q <= {identity_word(param_q[2:0], serial_number, hw_revision, fw_revision,
                     {date_year, date_month, date_day, date_hour}), 8'h00};
                  send_q <= {identity_word(param_q[2:0], serial_number, hw_revision, fw_revision,
                     {date_year, date_month, date_day, date_hour}), 8'h00};
               end else if (cmd_q == `QRR_CMD_LIST_POINT) begin
                  staged_q <= list_mem[param_q[10:0]];
                  send_q <= list_mem[param_q[10:0]];
               end else if (cmd_q == `QRR_CMD_LEVEL_DAC) begin
                  staged_q <= {level_dac_code, 24'h00_0000};
                  send_q <= {level_dac_code, 24'h00_0000};
               end else if (is_query(cmd_q)) begin
                  // other status queries sit outside this block and stage zeros
                  staged_q <= 40'h00_0000_0000;
                  send_q <= 40'h00_0000_0000;
               end else if (cmd_q == `QRR_CMD_DRAIN) begin
                  // drain hands back the staged reply and empties it
                  send_q <= staged_q;
                  staged_q <= 40'h00_0000_0000;
                  frame_error_q <= !serial_q || (param_cnt_q != `QRR_DRAIN_PARAM_BYTES) ||
                     (param_q != 40'h00_0000_0000);
               end else begin
                  // write-only command finished: single ack byte
                  send_q <= {`QRR_ACK_BYTE, 32'h0000_0000};
                  send_left_q <= 3'h1;
               end
            end
            QRR_D_SEND: begin
               if (link.d2h_ready) begin
                  send_q <= {send_q[31:0], 8'h00}; // msb first
                  send_left_q <= send_left_q - 3'h1;
                  if (send_left_q == 3'h1) begin
                     state_q <= QRR_D_CMD;
                  end
               end
            end
            default: state_q <= QRR_D_CMD;
         endcase
      end
   end

   // -----------------------------------------------------------
   // link outputs
   // -----------------------------------------------------------
   assign link.h2d_ready = (state_q == QRR_D_CMD) || (state_q == QRR_D_PARAM);
   assign link.d2h_valid = (state_q == QRR_D_SEND);
   assign link.d2h_data = send_q[39:32];
   assign last_cmd = last_cmd_q;
   assign frame_error = frame_error_q;
endmodule : qrr_device

// file: verilog/qrr_host.sv
// host end: sends one command frame and collects the answer
`timescale 1ns/1ps
`include "qrr_defs.svh"
module qrr_host (
   input wire logic clk_sys,
   input wire logic nrst,
   qrr_link_if.host link,
   input wire logic bridge_ready,
   input wire logic req_valid,
   input wire logic [7:0] req_cmd,
   input wire logic [39:0] req_param,
   input wire logic [2:0] req_param_bytes,
   input wire logic req_expect_reply,
   output logic req_ready,
   output logic resp_valid,
   output logic [39:0] resp_data
);
   typedef enum {QRR_H_IDLE, QRR_H_CMD, QRR_H_PARAM, QRR_H_RECV} qrr_host_state_t;
   qrr_host_state_t state_q;
   logic [7:0] cmd_q;
   logic [39:0] param_q;
   logic [2:0] param_left_q;
   logic [2:0] recv_left_q;
   logic [39:0] recv_q;
   logic resp_valid_q;
   logic bridge_m1_q;
   logic bridge_q;

   // bridge ready pin synchroniser
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bridge_m1_q <= 1'b0;
         bridge_q <= 1'b0;
      end else begin
         bridge_m1_q <= bridge_ready;
         bridge_q <= bridge_m1_q;
      end
   end

   // frame sender and answer collector
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= QRR_H_IDLE;
         cmd_q <= 8'h00;
         param_q <= 40'h00_0000_0000;
         param_left_q <= 3'h0;
         recv_left_q <= 3'h0;
         recv_q <= 40'h00_0000_0000;
         resp_valid_q <= 1'b0;
      end else begin
         resp_valid_q <= 1'b0;
         case (state_q)
            QRR_H_IDLE: begin
               if (req_valid && bridge_q) begin
                  cmd_q <= req_cmd;
                  // left align so the first parameter byte is the msb
                  param_q <= req_param << {(`QRR_REPLY_BYTES - req_param_bytes), 3'h0};
                  param_left_q <= req_param_bytes;
                  recv_left_q <= req_expect_reply ? `QRR_REPLY_BYTES : 3'h1;
                  recv_q <= 40'h00_0000_0000;
                  state_q <= QRR_H_CMD;
               end
            end
            QRR_H_CMD: begin
               if (link.h2d_ready) begin
                  state_q <= (param_left_q == 3'h0) ? QRR_H_RECV : QRR_H_PARAM;
               end
            end
            QRR_H_PARAM: begin
               if (link.h2d_ready) begin
                  param_q <= {param_q[31:0], 8'h00};
                  param_left_q <= param_left_q - 3'h1;
                  if (param_left_q == 3'h1) begin
                     state_q <= QRR_H_RECV;
                  end
               end
            end
            QRR_H_RECV: begin
               // ack or reply must be read before the next frame
               if (link.d2h_valid) begin
                  recv_q <= {recv_q[31:0], link.d2h_data};
                  recv_left_q <= recv_left_q - 3'h1;
                  if (recv_left_q == 3'h1) begin
                     resp_valid_q <= 1'b1;
                     state_q <= QRR_H_IDLE;
                  end
               end
            end
            default: state_q <= QRR_H_IDLE;
         endcase
      end
   end

   assign link.h2d_valid = (state_q == QRR_H_CMD) || (state_q == QRR_H_PARAM);
   assign link.h2d_data = (state_q == QRR_H_CMD) ? cmd_q : param_q[39:32];
   assign link.h2d_last = ((state_q == QRR_H_CMD) && (param_left_q == 3'h0)) ||
      ((state_q == QRR_H_PARAM) && (param_left_q == 3'h1));
   assign link.d2h_ready = (state_q == QRR_H_RECV);
   assign req_ready = (state_q == QRR_H_IDLE) && bridge_q;
   assign resp_valid = resp_valid_q;
   assign resp_data = recv_q;
endmodule : qrr_host

// file: verilog/qrr_link_if.sv
// byte link joining host end and device end
`timescale 1ns/1ps
interface qrr_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_last;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;
   modport host (output h2d_data, output h2d_valid, output h2d_last, input h2d_ready,
      input d2h_data, input d2h_valid, output d2h_ready);
   modport device (input h2d_data, input h2d_valid, input h2d_last, output h2d_ready,
      output d2h_data, output d2h_valid, input d2h_ready);
endinterface : qrr_link_if

// file: verilog/qrr_pkg.sv
// types used by the device end of the query register responder
package qrr_pkg;
   typedef logic [39:0] qrr_reply_t;
   typedef logic [7:0] qrr_byte_t;
endpackage : qrr_pkg
